// >>> design/ppfm_top.sv
// Shared peripheral pin bank: GPIO, video/audio out, stream capture, raw
// samples, pin interrupts, capture buffer and DMA word output.
// Assumes APB master, internal video/audio/converter sources and a DMA
// bus master all on CLK; pins arrive asynchronously.
`timescale 1ns/1ps
`include "ppfm_params.svh"
module ppfm_top
   import ppfm_pkg::*;
#(
   parameter int BUF_WORDS = `PPFM_BUF_WORDS,
   parameter int AUD_HALF  = `PPFM_AUD_HALF_CYC
) (
   input  wire logic           CLK,
   input  wire logic           RESET_N,
   input  wire logic           PSEL,
   input  wire logic           PENABLE,
   input  wire logic           PWRITE,
   input  wire logic [7:0]     PADDR,
   input  wire logic [31:0]    PWDATA,
   output logic [31:0]         PRDATA,
   output logic                PREADY,
   output logic                PSLVERR,
   input  wire logic [27:0]    GPIO_IN,
   output logic [27:0]         GPIO_OUT,
   output logic [27:0]         GPIO_OE,
   output logic                VCLK_OUT,
   input  wire ppfm_video_type VIDEO,
   input  wire logic [8:0]     ADC_Y,
   input  wire logic [8:0]     ADC_C,
   input  wire logic [15:0]    AUD_LEFT,
   input  wire logic [15:0]    AUD_RIGHT,
   input  wire logic           CAP_VALID,
   input  wire ppfm_entry_type CAP_ENTRY,
   input  wire logic           DMA_READY,
   output logic                DMA_VALID,
   output ppfm_entry_type      DMA_ENTRY,
   output logic                INT_OUT
);
   localparam int PW = $clog2(BUF_WORDS);
   localparam logic [1:0] TS_CHAN = 2'h3;

   function automatic logic [7:0] sync_code(input logic f, input logic v,
                                            input logic h);
      sync_code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction : sync_code

   logic [31:0]          ctrl;
   logic [27:0]          gpio_out_reg;
   logic [27:0]          gpio_oe_reg;
   logic [27:0]          strap;
   logic [31:0]          dma_thr;
   logic [`PPFM_INT_BITS-1:0] int_stat;
   logic [`PPFM_INT_BITS-1:0] int_mask;
   logic [27:0]          pin_s1;
   logic [27:0]          pin_s2;
   logic [27:0]          pin_s3;
   ppfm_mode_type        mode;
   logic                 wr_en;
   logic                 rd_en;
   logic [31:0]          next_rdata;
   logic                 next_err;
   ppfm_entry_type       mem [BUF_WORDS];
   logic [PW-1:0]        wr_ptr;
   logic [PW-1:0]        rd_ptr;
   logic [PW:0]          level;
   logic                 push;
   logic                 pop;
   ppfm_entry_type       push_entry;
   logic                 overflow;
   logic                 dma_active;
   logic                 ts_edge;
   logic [7:0]           ts_byte;
   logic                 ts_byte_ok;
   logic [2:0]           ts_bit_idx;
   logic [7:0]           ts_shift;
   logic [1:0]           ts_byte_idx;
   logic [31:0]          ts_word;
   logic                 ts_word_ok;
   logic                 vclk;
   logic                 act_d;
   ppfm_code_type        code_st;
   logic                 code_eav;
   logic [7:0]           code_byte;
   logic [$clog2(AUD_HALF+1)-1:0] aud_cnt;
   logic                 sck;
   logic [4:0]           aud_bit;
   logic [31:0]          aud_shift;
   logic [17:0]          raw_hold;
   logic [27:0]          func_out;
   logic [27:0]          func_oe;
   logic [`PPFM_INT_BITS-1:0] int_set;

   assign mode  = ppfm_mode_type'(ctrl[`PPFM_CTRL_MODE_LSB +: 2]);
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
   assign rd_en = PSEL && PENABLE && !PREADY;

   // Pin synchronisers
   always_ff @(posedge CLK) begin
      pin_s1 <= GPIO_IN;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
   end

   // Strap capture while reset is held
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         strap <= pin_s2;
      end
   end

   // APB answer one cycle into the access phase
   always_comb begin
      next_err = 1'b0;
      unique case (PADDR)
         `PPFM_REG_CTRL:      next_rdata = ctrl;
         `PPFM_REG_GPIO_OUT:  next_rdata = {4'h0, gpio_out_reg};
         `PPFM_REG_GPIO_OE:   next_rdata = {4'h0, gpio_oe_reg};
         `PPFM_REG_GPIO_IN:   next_rdata = {4'h0, pin_s2};
         `PPFM_REG_STRAP:     next_rdata = {4'h0, strap};
         `PPFM_REG_INT_STAT:  next_rdata = {27'h0, int_stat};
         `PPFM_REG_INT_MASK:  next_rdata = {27'h0, int_mask};
         `PPFM_REG_BUF_LEVEL: next_rdata = 32'(level);
         `PPFM_REG_DMA_THR:   next_rdata = dma_thr;
         default: begin
            next_rdata = 32'h0000_0000;
            next_err   = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && PENABLE && !PREADY;
         PSLVERR <= PSEL && PENABLE && !PREADY && next_err;
         if (rd_en && !PWRITE) begin
            PRDATA <= next_rdata;
         end
      end
   end

   // Software registers
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ctrl         <= `PPFM_CTRL_RESET;
         gpio_out_reg <= 28'h0000000;
         gpio_oe_reg  <= 28'h0000000;
         int_mask     <= 5'h00;
         dma_thr      <= `PPFM_THR_RESET;
      end else if (wr_en) begin
         unique case (PADDR)
            `PPFM_REG_CTRL:     ctrl <= {25'h0, PWDATA[6:0]};
            `PPFM_REG_GPIO_OUT: gpio_out_reg <= PWDATA[27:0];
            `PPFM_REG_GPIO_OE:  gpio_oe_reg <= PWDATA[27:0];
            `PPFM_REG_INT_MASK: int_mask <= PWDATA[4:0];
            `PPFM_REG_DMA_THR:  dma_thr <= PWDATA;
            default: ;
         endcase
      end
   end

   // Interrupt events: rising pin levels and buffer overflow
   always_comb begin
      int_set = 5'h00;
      int_set[`PPFM_INT_HSYNC] = pin_s2[`PPFM_PIN_HS] &
                                 !pin_s3[`PPFM_PIN_HS];
      int_set[`PPFM_INT_VSYNC] = pin_s2[`PPFM_PIN_VS] &
                                 !pin_s3[`PPFM_PIN_VS];
      int_set[`PPFM_INT_AUX_TWO] = pin_s2[`PPFM_PIN_AUX_TWO] &
                                   !pin_s3[`PPFM_PIN_AUX_TWO];
      int_set[`PPFM_INT_VALID] = pin_s2[`PPFM_PIN_VALID] &
                                 !pin_s3[`PPFM_PIN_VALID];
      int_set[`PPFM_INT_OVERFLOW] = overflow;
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         int_stat <= 5'h00;
         INT_OUT  <= 1'b0;
      end else begin
         if (wr_en && PADDR == `PPFM_REG_INT_STAT) begin
            int_stat <= (int_stat & ~PWDATA[4:0]) | int_set;
         end else begin
            int_stat <= int_stat | int_set;
         end
         INT_OUT <= |(int_stat & int_mask);
      end
   end

   // Stream capture from the channel decoder
   assign ts_edge = pin_s2[`PPFM_PIN_TSCLK] && !pin_s3[`PPFM_PIN_TSCLK] &&
                    pin_s2[`PPFM_PIN_VALID] && pin_s2[`PPFM_PIN_VS] &&
                    mode == PPFM_TSIN;

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ts_bit_idx <= 3'h0;
         ts_shift   <= 8'h00;
         ts_byte    <= 8'h00;
         ts_byte_ok <= 1'b0;
      end else begin
         ts_byte_ok <= 1'b0;
         if (ts_edge && ctrl[`PPFM_CTRL_SERIAL]) begin
            if (pin_s2[`PPFM_PIN_SOP]) begin
               ts_shift   <= {7'h00, pin_s2[`PPFM_PIN_SER]};
               ts_bit_idx <= 3'h1;
            end else begin
               ts_shift   <= {ts_shift[6:0], pin_s2[`PPFM_PIN_SER]};
               ts_bit_idx <= ts_bit_idx + 3'h1;
               if (ts_bit_idx == 3'h7) begin
                  ts_byte    <= {ts_shift[6:0], pin_s2[`PPFM_PIN_SER]};
                  ts_byte_ok <= 1'b1;
               end
            end
         end else if (ts_edge) begin
            ts_byte    <= pin_s2[7:0];
            ts_byte_ok <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ts_byte_idx <= 2'h0;
         ts_word     <= 32'h0000_0000;
         ts_word_ok  <= 1'b0;
      end else begin
         ts_word_ok <= 1'b0;
         if (ts_edge && pin_s2[`PPFM_PIN_SOP]) begin
            ts_byte_idx <= 2'h0;
         end
         if (ts_byte_ok) begin
            ts_word[8*ts_byte_idx +: 8] <= ts_byte;
            ts_byte_idx <= ts_byte_idx + 2'h1;
            ts_word_ok  <= ts_byte_idx == 2'h3;
         end
      end
   end

   // Capture buffer, stream capture first, internal captures second
   always_comb begin
      push       = 1'b0;
      push_entry = CAP_ENTRY;
      if (ts_word_ok) begin
         push       = 1'b1;
         push_entry = '{chan: TS_CHAN, data: ts_word};
      end else if (CAP_VALID) begin
         push = 1'b1;
      end
   end

   assign overflow = (push && level == (PW+1)'(BUF_WORDS)) ||
                     (ts_word_ok && CAP_VALID);
   assign pop = (level != '0) && dma_active && (!DMA_VALID || DMA_READY);

   always_ff @(posedge CLK) begin
      if (push && level != (PW+1)'(BUF_WORDS)) begin
         mem[wr_ptr] <= push_entry;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (push && level != (PW+1)'(BUF_WORDS)) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         level <= level + (PW+1)'(push && level != (PW+1)'(BUF_WORDS))
                  - (PW+1)'(pop);
      end
   end

   // DMA write requests driven by fill level
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         dma_active <= 1'b0;
         DMA_VALID  <= 1'b0;
         DMA_ENTRY  <= '0;
      end else begin
         if (!ctrl[`PPFM_CTRL_DMA_EN] || level == '0) begin
            dma_active <= 1'b0;
         end else if (32'(level) >= dma_thr) begin
            dma_active <= 1'b1;
         end
         if (pop) begin
            DMA_VALID <= 1'b1;
            DMA_ENTRY <= mem[rd_ptr];
         end else if (DMA_READY) begin
            DMA_VALID <= 1'b0;
         end
      end
   end

   // Output clock for video and raw modes
   always_ff @(posedge CLK) begin
      if (!RESET_N || mode == PPFM_GPIO || mode == PPFM_TSIN) begin
         vclk <= 1'b0;
      end else begin
         vclk <= !vclk;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         raw_hold <= 18'h00000;
      end else if (!vclk) begin
         raw_hold <= {ADC_Y, ADC_C};
      end
   end

   // Start and end code sequencer for embedded sync
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         act_d    <= 1'b0;
         code_st  <= CODE_IDLE;
         code_eav <= 1'b0;
      end else begin
         act_d <= VIDEO.active;
         unique case (code_st)
            CODE_IDLE: begin
               if (VIDEO.active != act_d) begin
                  code_st  <= CODE_FF;
                  code_eav <= act_d;
               end
            end
            CODE_FF: code_st <= CODE_Z1;
            CODE_Z1: code_st <= CODE_Z2;
            CODE_Z2: code_st <= CODE_XY;
            CODE_XY: code_st <= CODE_IDLE;
            default: code_st <= CODE_IDLE;
         endcase
      end
   end

   always_comb begin
      unique case (code_st)
         CODE_FF: code_byte = 8'hFF;
         CODE_XY: code_byte = sync_code(VIDEO.field, VIDEO.vsync, code_eav);
         default: code_byte = 8'h00;
      endcase
   end

   // Serial audio output
   always_ff @(posedge CLK) begin
      if (!RESET_N || !ctrl[`PPFM_CTRL_AUDIO] || mode != PPFM_AVOUT) begin
         aud_cnt   <= '0;
         sck       <= 1'b0;
         aud_bit   <= 5'h1F;
         aud_shift <= 32'h0000_0000;
      end else if (aud_cnt == ($bits(aud_cnt))'(AUD_HALF - 1)) begin
         aud_cnt <= '0;
         sck     <= !sck;
         if (sck) begin
            aud_bit <= aud_bit + 5'h01;
            if (aud_bit == 5'h1F) begin
               aud_shift <= {AUD_LEFT, AUD_RIGHT};
            end else begin
               aud_shift <= {aud_shift[30:0], 1'b0};
            end
         end
      end else begin
         aud_cnt <= aud_cnt + 1'b1;
      end
   end

   // Function drive per mode; pins a function leaves alone stay GPIO
   always_comb begin
      func_out = 28'h0000000;
      func_oe  = 28'h0000000;
      unique case (mode)
         PPFM_AVOUT: begin
            func_oe[15:8]  = 8'hFF;
            func_out[15:8] = VIDEO.data[15:8];
            if (ctrl[`PPFM_CTRL_WIDE]) begin
               func_oe[7:0]  = 8'hFF;
               func_out[7:0] = VIDEO.data[7:0];
            end
            func_oe[`PPFM_PIN_AUX_ONE]  = 1'b1;
            func_out[`PPFM_PIN_AUX_ONE] = VIDEO.aux_one;
            func_oe[`PPFM_PIN_AUX_TWO]  = 1'b1;
            func_out[`PPFM_PIN_AUX_TWO] = VIDEO.aux_two;
            if (ctrl[`PPFM_CTRL_EMBSYNC]) begin
               if (code_st != CODE_IDLE) begin
                  func_out[15:8] = code_byte;
                  func_out[7:0]  = code_byte;
               end
            end else begin
               func_oe[`PPFM_PIN_HS]  = 1'b1;
               func_out[`PPFM_PIN_HS] = VIDEO.hsync;
               func_oe[`PPFM_PIN_VS]  = 1'b1;
               func_out[`PPFM_PIN_VS] = VIDEO.vsync;
            end
            if (ctrl[`PPFM_CTRL_AUDIO]) begin
               func_oe[27:25]  = 3'h7;
               func_out[27:25] = {aud_shift[31], aud_bit[4], sck};
            end
         end
         PPFM_TSIN: begin
            func_oe = 28'h0000000;
         end
         PPFM_RAW: begin
            func_oe[15:8]  = 8'hFF;
            func_out[15:8] = raw_hold[17:10];
            func_oe[`PPFM_PIN_AUX_ONE]  = 1'b1;
            func_out[`PPFM_PIN_AUX_ONE] = raw_hold[9];
            func_oe[7:0]   = 8'hFF;
            func_out[7:0]  = raw_hold[8:1];
            func_oe[`PPFM_PIN_HS]  = 1'b1;
            func_out[`PPFM_PIN_HS] = raw_hold[0];
         end
         PPFM_GPIO: ;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         GPIO_OUT <= 28'h0000000;
         GPIO_OE  <= 28'h0000000;
         VCLK_OUT <= 1'b0;
      end else begin
         GPIO_OUT <= (func_oe & func_out) | (~func_oe & gpio_out_reg);
         GPIO_OE  <= func_oe | (gpio_oe_reg & ~func_oe);
         VCLK_OUT <= vclk;
      end
   end
endmodule : ppfm_top

// >>> include/ppfm_params.svh
// Offsets, field positions, reset values and timing counts of the pin mux.
// Assumes a 32-bit APB register window and a 25 MHz core clock.
`ifndef PPFM_PARAMS_SVH
`define PPFM_PARAMS_SVH
`define PPFM_CLK_NS        40
`define PPFM_REG_CTRL      8'h00
`define PPFM_REG_GPIO_OUT  8'h04
`define PPFM_REG_GPIO_OE   8'h08
`define PPFM_REG_GPIO_IN   8'h0C
`define PPFM_REG_STRAP     8'h10
`define PPFM_REG_INT_STAT  8'h14
`define PPFM_REG_INT_MASK  8'h18
`define PPFM_REG_BUF_LEVEL 8'h1C
`define PPFM_REG_DMA_THR   8'h20
`define PPFM_CTRL_MODE_LSB 0
`define PPFM_CTRL_SERIAL   2
`define PPFM_CTRL_WIDE     3
`define PPFM_CTRL_EMBSYNC  4
`define PPFM_CTRL_AUDIO    5
`define PPFM_CTRL_DMA_EN   6
`define PPFM_CTRL_RESET    32'h0000_0000
`define PPFM_THR_RESET     32'h0000_0040
`define PPFM_INT_HSYNC     0
`define PPFM_INT_VSYNC     1
`define PPFM_INT_AUX_TWO   2
`define PPFM_INT_VALID     3
`define PPFM_INT_OVERFLOW  4
`define PPFM_INT_BITS      5
`define PPFM_PIN_SDO       27
`define PPFM_PIN_WS        26
`define PPFM_PIN_SCK       25
`define PPFM_PIN_HS        23
`define PPFM_PIN_VS        22
`define PPFM_PIN_SER       21
`define PPFM_PIN_TSCLK     20
`define PPFM_PIN_SOP       19
`define PPFM_PIN_AUX_TWO   18
`define PPFM_PIN_AUX_ONE   17
`define PPFM_PIN_VALID     16
`define PPFM_NUM_PINS      28
`define PPFM_BUF_BYTES     1024
`define PPFM_BUF_WORDS     (`PPFM_BUF_BYTES / 4)
`define PPFM_AUD_HALF_NS   160
`define PPFM_AUD_HALF_CYC  (`PPFM_AUD_HALF_NS / `PPFM_CLK_NS)
`endif

// >>> include/ppfm_pkg.sv
// Types shared by the pin mux and its bench.
// Assumes ppfm_params.svh for all numeric constants.
package ppfm_pkg;
   typedef enum logic [1:0] {
      PPFM_GPIO  = 2'b00,
      PPFM_AVOUT = 2'b01,
      PPFM_TSIN  = 2'b10,
      PPFM_RAW   = 2'b11
   } ppfm_mode_type;
   typedef enum logic [2:0] {
      CODE_IDLE = 3'b000,
      CODE_FF   = 3'b001,
      CODE_Z1   = 3'b010,
      CODE_Z2   = 3'b011,
      CODE_XY   = 3'b100
   } ppfm_code_type;
   typedef struct packed {
      logic [1:0]  chan;
      logic [31:0] data;
   } ppfm_entry_type;
   typedef struct packed {
      logic [15:0] data;
      logic        hsync;
      logic        vsync;
      logic        aux_one;
      logic        aux_two;
      logic        active;
      logic        field;
   } ppfm_video_type;
endpackage : ppfm_pkg

// >>> bench/ppfm_monitor.sv
// Checker for the pin mux: APB, pin, interrupt and DMA timing.
// Assumes it is bound to ppfm_top and sees only its ports.
`timescale 1ns/1ps
`include "ppfm_params.svh"
module ppfm_monitor
   import ppfm_pkg::*;
(
   input wire logic           CLK,
   input wire logic           RESET_N,
   input wire logic           PSEL,
   input wire logic           PENABLE,
   input wire logic           PWRITE,
   input wire logic [7:0]     PADDR,
   input wire logic [31:0]    PWDATA,
   input wire logic           PREADY,
   input wire logic           PSLVERR,
   input wire logic [27:0]    GPIO_OUT,
   input wire logic [27:0]    GPIO_OE,
   input wire logic           VCLK_OUT,
   input wire logic           DMA_READY,
   input wire logic           DMA_VALID,
   input wire ppfm_entry_type DMA_ENTRY,
   input wire logic           INT_OUT
);
   logic        wr_ok;
   logic [1:0]  mode_q;
   logic [1:0]  age;
   logic [27:0] out_q;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   // Mode last written and cycles since
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         mode_q <= 2'b00;
         age    <= 2'h0;
      end else if (wr_ok && PADDR == `PPFM_REG_CTRL) begin
         mode_q <= PWDATA[1:0];
         age    <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   always_ff @(posedge CLK) begin
      if (wr_ok && PADDR == `PPFM_REG_GPIO_OUT) begin
         out_q <= PWDATA[27:0];
      end
   end
   property p_rst_quiet;
      $rose(RESET_N) |-> GPIO_OE == 28'h0 && !INT_OUT && !DMA_VALID;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
   property p_gpio_clk;
      mode_q == PPFM_GPIO && age == 2'h3 |-> !VCLK_OUT;
   endproperty
   a_gpio_clk: assert property (p_gpio_clk)
      else $error("video clock runs in gpio mode");
   property p_gpio_out;
      wr_ok && PADDR == `PPFM_REG_GPIO_OUT && mode_q == PPFM_GPIO
         |-> ##2 GPIO_OUT == out_q;
   endproperty
   a_gpio_out: assert property (p_gpio_out)
      else $error("pin drive differs from written value");
   property p_ready;
      PREADY |=> !PREADY;
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready longer than one cycle");
   property p_err;
      PSLVERR |-> PREADY;
   endproperty
   a_err: assert property (p_err)
      else $error("error without ready");
   property p_mask;
      wr_ok && PADDR == `PPFM_REG_INT_MASK && PWDATA[4:0] == 5'h0
         |-> ##3 !INT_OUT;
   endproperty
   a_mask: assert property (p_mask)
      else $error("interrupt with all enables clear");
   property p_video;
      mode_q == PPFM_AVOUT && age == 2'h3 |-> GPIO_OE[15:8] == 8'hFF;
   endproperty
   a_video: assert property (p_video)
      else $error("video byte lane not driven");
   property p_raw_clk;
      mode_q == PPFM_RAW && age == 2'h3 && !wr_ok
         |=> VCLK_OUT != $past(VCLK_OUT);
   endproperty
   a_raw_clk: assert property (p_raw_clk)
      else $error("converter clock not toggling");
   property p_dma_hold;
      DMA_VALID && !DMA_READY |=> DMA_VALID && $stable(DMA_ENTRY);
   endproperty
   a_dma_hold: assert property (p_dma_hold)
      else $error("dma word dropped before ready");
   c_irq: cover property ($rose(INT_OUT));
   c_dma: cover property (DMA_VALID && DMA_READY);
   c_err: cover property (PREADY && PSLVERR);
endmodule : ppfm_monitor
bind ppfm_top ppfm_monitor u_mon (
   .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
   .VCLK_OUT(VCLK_OUT), .DMA_READY(DMA_READY), .DMA_VALID(DMA_VALID),
   .DMA_ENTRY(DMA_ENTRY), .INT_OUT(INT_OUT)
);

// >>> bench/ppfm_partner.sv
// Stream source standing for the external channel decoder.
// Assumes the bench merges its pins into the shared pin bank.
`timescale 1ns/1ps
module ppfm_partner
   import ppfm_pkg::*;
(
   input  wire logic   on,
   output logic [27:0] pins,
   output logic [27:0] pins_en
);
   // Lock, serial, clock, packet start, valid and byte lines
   assign pins_en = on ? 28'h07900FF : 28'h0;
   initial begin
      pins = 28'h0400000;
   end
   // Clock runs only inside a frame, 320 ns period
   task automatic send(input logic [31:0] w, input logic ser);
      #5;
      for (int i = 0; i < (ser ? 32 : 4); i++) begin
         pins[19] = (i == 0);
         pins[16] = 1'b1;
         if (ser) pins[21] = w[8 * (i / 8) + 7 - i % 8];
         else pins[7:0] = w[8 * i +: 8];
         #160 pins[20] = 1'b1;
         #160 pins[20] = 1'b0;
      end
      pins[16] = 1'b0;
      pins[19] = 1'b0;
      pins[21] = ~pins[21];
      pins[7:0] = ~pins[7:0];
   endtask : send
endmodule : ppfm_partner

// >>> bench/ppfm_tb.sv
// Testbench for the pin mux: APB tasks, stream source, DMA sink.
// Assumes ppfm_top on a 25 MHz clock with synchronous reset.
`timescale 1ns/1ps
`include "ppfm_params.svh"
module tb
   import ppfm_pkg::*;
;
   logic           clk = 1'b0;
   logic           rst_n = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata, q;
   logic           pready, pslverr, e, vclk, dma_valid, int_out;
   logic           cap_valid = 1'b0;
   logic           dma_ready = 1'b0;
   logic           sp_on = 1'b0;
   logic [27:0]    tb_pins = 28'h5A3C0F1;
   logic [27:0]    gpio_in, gpio_out, gpio_oe, sp_pins, sp_en;
   logic [8:0]     adc_y = 9'h000;
   logic [8:0]     adc_c = 9'h000;
   ppfm_video_type video = '0;
   ppfm_entry_type cap_entry = '0;
   ppfm_entry_type dma_entry;
   int             err_count = 0;
   int             samples_checked = 0;
   int             cyc = 0;
   int             pin_t [6] = '{23, 22, 18, 16, 24, 17};
   logic [31:0]    stat_t [6] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h0, 32'h0};
   assign gpio_in = (gpio_oe & gpio_out) |
      (~gpio_oe & ((sp_en & sp_pins) | (~sp_en & tb_pins)));
   ppfm_top uut (
      .CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe),
      .VCLK_OUT(vclk), .VIDEO(video), .ADC_Y(adc_y), .ADC_C(adc_c),
      .AUD_LEFT(16'h5AA5), .AUD_RIGHT(16'hA55A),
      .CAP_VALID(cap_valid), .CAP_ENTRY(cap_entry),
      .DMA_READY(dma_ready), .DMA_VALID(dma_valid),
      .DMA_ENTRY(dma_entry), .INT_OUT(int_out)
   );
   ppfm_partner sp (.on(sp_on), .pins(sp_pins), .pins_en(sp_en));
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic er);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        er;
      xfer(1'b1, a, d, r, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        er;
      xfer(1'b0, a, 32'h0, r, er);
      chk(r, x);
   endtask : rd
   // Waits for a DMA word, stalls two cycles, then accepts it
   task automatic take(input logic [1:0] c, input logic [31:0] d);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dma_valid !== 1'b1 && n < 600);
      if (n >= 600) err_count++;
      repeat (2) @(posedge clk);
      chk({30'h0, dma_entry.chan}, {30'h0, c});
      chk(dma_entry.data, d);
      dma_ready <= 1'b1;
      @(posedge clk);
      dma_ready <= 1'b0;
   endtask : take
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(`PPFM_REG_CTRL, `PPFM_CTRL_RESET);
      rd(`PPFM_REG_DMA_THR, `PPFM_THR_RESET);
      rd(`PPFM_REG_INT_MASK, 32'h0);
      rd(`PPFM_REG_STRAP, 32'h05A3C0F1);
      xfer(1'b0, 8'h24, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      $display("reset test done");
      wr(`PPFM_REG_GPIO_OE, 32'h0FFFFFFF);
      wr(`PPFM_REG_GPIO_OUT, 32'h0C35A96E);
      repeat (2) @(posedge clk);
      rd(`PPFM_REG_GPIO_IN, 32'h0C35A96E);
      chk({4'h0, gpio_out}, 32'h0C35A96E);
      tb_pins <= 28'h3E1D4B7;
      wr(`PPFM_REG_GPIO_OE, 32'h0);
      repeat (4) @(posedge clk);
      rd(`PPFM_REG_GPIO_IN, 32'h03E1D4B7);
      rd(`PPFM_REG_STRAP, 32'h05A3C0F1);
      $display("gpio test done");
      for (int i = 0; i < 6; i++) begin
         tb_pins[pin_t[i]] <= 1'b0;
         repeat (4) @(posedge clk);
         wr(`PPFM_REG_INT_STAT, 32'h1F);
         tb_pins[pin_t[i]] <= 1'b1;
         repeat (4) @(posedge clk);
         rd(`PPFM_REG_INT_STAT, stat_t[i]);
         if (stat_t[i] != 32'h0) begin
            wr(`PPFM_REG_INT_MASK, stat_t[i]);
            repeat (3) @(posedge clk);
            chk({31'h0, int_out}, 32'h1);
            wr(`PPFM_REG_INT_STAT, stat_t[i]);
            repeat (3) @(posedge clk);
            chk({31'h0, int_out}, 32'h0);
         end
      end
      wr(`PPFM_REG_INT_MASK, 32'h0);
      $display("interrupt test done");
      video <= {16'h1234, 6'b100000};
      wr(`PPFM_REG_CTRL, 32'h01);
      repeat (4) @(posedge clk);
      chk({16'h0, gpio_oe[15:0]}, 32'hFF00);
      chk({30'h0, gpio_out[23:22]}, 32'h2);
      wr(`PPFM_REG_CTRL, 32'h29);
      repeat (4) @(posedge clk);
      chk({16'h0, gpio_oe[15:0]}, 32'hFFFF);
      wr(`PPFM_REG_CTRL, 32'h11);
      video.active <= 1'b1;
      repeat (3) @(posedge clk);
      chk({24'h0, gpio_out[15:8]}, 32'hFF);
      repeat (3) @(posedge clk);
      chk({24'h0, gpio_out[15:8]}, 32'h80);
      adc_y <= 9'h1AB;
      adc_c <= 9'h0D5;
      wr(`PPFM_REG_CTRL, 32'h03);
      repeat (6) @(posedge clk);
      chk({16'h0, gpio_out[15:0]}, 32'hD56A);
      chk({30'h0, gpio_out[23], gpio_out[17]}, 32'h3);
      $display("video test done");
      wr(`PPFM_REG_DMA_THR, 32'h1);
      sp_on <= 1'b1;
      wr(`PPFM_REG_CTRL, 32'h42);
      sp.send(32'hC3A55A3C, 1'b0);
      take(2'h3, 32'hC3A55A3C);
      wr(`PPFM_REG_CTRL, 32'h46);
      sp.send(32'h81427E18, 1'b1);
      take(2'h3, 32'h81427E18);
      $display("stream test done");
      wr(`PPFM_REG_CTRL, 32'h02);
      wr(`PPFM_REG_INT_STAT, 32'h1F);
      for (int i = 0; i < 257; i++) begin
         @(posedge clk);
         cap_valid <= 1'b1;
         cap_entry <= {2'h1, 32'(i)};
      end
      @(posedge clk);
      cap_valid <= 1'b0;
      rd(`PPFM_REG_BUF_LEVEL, 32'h100);
      rd(`PPFM_REG_INT_STAT, 32'h10);
      wr(`PPFM_REG_INT_MASK, 32'h10);
      repeat (3) @(posedge clk);
      chk({31'h0, int_out}, 32'h1);
      wr(`PPFM_REG_CTRL, 32'h42);
      for (int i = 0; i < 256; i++) take(2'h1, 32'(i));
      rd(`PPFM_REG_BUF_LEVEL, 32'h0);
      $display("buffer test done");
      results();
   end
endmodule : tb
